// *** verilog/bce_pkg.sv ***
package bce_pkg;
	// Opcodes handled by this block
	localparam logic [7:0] OP_REL_Z    = 8'h28;
	localparam logic [7:0] OP_REL_NZ   = 8'h20;
	localparam logic [7:0] OP_LOOP     = 8'h10;
	localparam logic [7:0] OP_IND_JUMP = 8'he9;
	localparam logic [7:0] OP_PFX_ONE  = 8'hdd;
	localparam logic [7:0] OP_PFX_TWO  = 8'hfd;
	localparam logic [7:0] OP_CALL     = 8'hcd;

	// T-state lengths of the machine cycles
	localparam logic [2:0] T_FETCH      = 3'h4;
	localparam logic [2:0] T_FETCH_LONG = 3'h5;
	localparam logic [2:0] T_READ       = 3'h3;
	localparam logic [2:0] T_BRANCH     = 3'h5;
	localparam logic [2:0] T_CALL_RD2   = 3'h4;
	localparam logic [2:0] T_WRITE      = 3'h3;

	// Bytes of a relative branch and of a call
	localparam logic [15:0] REL_LEN  = 16'h0002;
	localparam logic [15:0] CALL_LEN = 16'h0003;

	// Reset values
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] SP_RESET = 16'hffff;

	// One memory bus request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} bce_mreq_t;

	// Architectural registers visible to this block
	typedef struct packed {
		logic [15:0] pointerPair;
		logic [15:0] firstIndexReg;
		logic [15:0] secondIndexReg;
		logic [7:0]  countReg;
		logic        zeroFlag;
	} bce_regs_t;
endpackage

// *** verilog/bce_tstate_timer.sv ***
`timescale 1ns/100ps
// Counts the T-states of one machine cycle and flags its last one
module bce_tstate_timer
	import bce_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       nrst,
	// Control
	input  wire logic       start,
	input  wire logic [2:0] length,
	// Status
	output logic            lastT
);
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;

	// Load the full length on start, then count down; a count of one is the last T-state
	always_comb begin
		cnt_d = cnt_q;
		if (start)
			cnt_d = length;
		else if (cnt_q != 3'h0)
			cnt_d = cnt_q - 3'h1;
	end

	// Reset preloads one opcode fetch, so the sequencer needs no start-up kick
	always_ff @(posedge core_clk) begin
		if (!nrst)
			cnt_q <= T_FETCH;
		else
			cnt_q <= cnt_d;
	end

	assign lastT = (cnt_q == 3'h1);
endmodule

// *** verilog/branch_and_call_exec.sv ***
`timescale 1ns/100ps
// Operation
// - Relative jump on zero branches by displacement when zero flag is 1.
// - Relative jump on not-zero falls through when zero flag is 1.
// - Relative targets reach -126 to +129 bytes from the opcode address.
// - Displacement is added to program counter already advanced by two.
// - Taken conditional relative jump: three machine cycles, 4+3+5 T-states.
// - Untaken conditional relative jump: two machine cycles, 4+3 T-states.
// - Indirect jump through pointer pair: one cycle of four T-states.
// - First index prefix plus E9 loads counter from it in 4+4.
// - Second index prefix plus E9 loads counter from it in 4+4.
// - Loop decrements count, branches if nonzero in 5+3+5 T-states.
// - Loop count reaching zero falls through in 5+3 T-states.
// - Call pushes program counter then loads the operand as entry.
// - Push decrements stack pointer, writes high byte, decrements, writes low.
// - Call operand is read low byte first, right after the opcode.
// - Pushed return address is the program counter advanced by three.
module branch_and_call_exec
	import bce_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// Register file view
	input  wire bce_regs_t   regsIn,
	output logic [7:0]       countOut,
	output logic             countWe,
	output logic             flagsWe,
	// Memory bus
	output bce_mreq_t        memReq,
	input  wire logic [7:0]  memRdata,
	// Architectural state
	output logic [15:0]      programCounter,
	output logic [15:0]      stackPointer,
	output logic             instrDone,
	output logic             illegalOp
);
	typedef enum {
		S_FETCH, S_FETCH2, S_DISP, S_BRANCH, S_OPLO, S_OPHI, S_PUSHHI, S_PUSHLO
	} bce_state_t;

	bce_state_t  state_q, state_d;
	logic [15:0] pc_q, pc_d;
	logic [15:0] sp_q, sp_d;
	logic [7:0]  disp_q, disp_d;
	logic [7:0]  lo_q, lo_d;
	logic [15:0] tgt_q, tgt_d;
	logic [1:0]  pfx_q, pfx_d;
	logic        long_q, long_d;
	logic [7:0]  cnt_q, cnt_d;
	logic        done_q, done_d;
	logic        ill_q, ill_d;
	logic        tStart;
	logic [2:0]  tLen;
	logic        lastT;
	bce_mreq_t   req;
	logic [7:0]  loopCount;

	// Sign-extended relative target from the advanced counter
	function automatic logic [15:0] relTarget(input logic [15:0] pc, input logic [7:0] d);
		relTarget = pc + {{8{d[7]}}, d};
	endfunction

	assign loopCount = regsIn.countReg - 8'h01;

	bce_tstate_timer u_timer (
		.core_clk (core_clk),
		.nrst     (nrst),
		.start    (tStart),
		.length   (tLen),
		.lastT    (lastT)
	);

	// Sequencer: each state is one machine cycle; moves on its last T-state
	always_comb begin
		state_d = state_q;
		pc_d    = pc_q;
		sp_d    = sp_q;
		disp_d  = disp_q;
		lo_d    = lo_q;
		tgt_d   = tgt_q;
		pfx_d   = pfx_q;
		long_d  = long_q;
		cnt_d   = cnt_q;
		done_d  = 1'b0;
		ill_d   = 1'b0;
		tStart  = 1'b0;
		tLen    = T_FETCH;
		req     = '0;
		case (state_q)
			S_FETCH: begin
				req.rd   = 1'b1;
				req.addr = pc_q;
				if (lastT) begin
					pc_d   = pc_q + 16'h0001;
					tStart = 1'b1;
					tLen   = T_READ;
					long_d = 1'b0;
					pfx_d  = 2'h0;
					case (memRdata)
						OP_REL_Z, OP_REL_NZ: state_d = S_DISP;
						OP_CALL:             state_d = S_OPLO;
						OP_LOOP: begin
							// Loop fetch is one T-state longer; the extra T runs as a short cycle
							long_d = 1'b1;
							state_d = S_FETCH2;
							tLen   = T_FETCH_LONG - T_FETCH;
						end
						OP_IND_JUMP: begin
							pc_d   = regsIn.pointerPair;
							tLen   = T_FETCH;
							done_d = 1'b1;
						end
						OP_PFX_ONE, OP_PFX_TWO: begin
							pfx_d   = (memRdata == OP_PFX_ONE) ? 2'h1 : 2'h2;
							state_d = S_FETCH2;
							tLen    = T_FETCH;
						end
						default: begin
							// Not ours: skip the byte and flag it
							ill_d  = 1'b1;
							tLen   = T_FETCH;
						end
					endcase
				end
			end
			S_FETCH2: begin
				// Second fetch after a prefix, or tail of the long loop fetch
				req.rd   = (pfx_q != 2'h0);
				req.addr = pc_q;
				if (lastT) begin
					tStart = 1'b1;
					if (long_q) begin
						cnt_d   = loopCount;
						state_d = S_DISP;
						tLen    = T_READ;
					end else begin
						state_d = S_FETCH;
						tLen    = T_FETCH;
						done_d  = 1'b1;
						if (memRdata == OP_IND_JUMP)
							pc_d = (pfx_q == 2'h1) ? regsIn.firstIndexReg : regsIn.secondIndexReg;
						else begin
							pc_d  = pc_q + 16'h0001;
							ill_d = 1'b1;
						end
					end
				end
			end
			S_DISP: begin
				req.rd   = 1'b1;
				req.addr = pc_q;
				if (lastT) begin
					pc_d   = pc_q + 16'h0001;
					disp_d = memRdata;
					tStart = 1'b1;
					if (long_q ? (cnt_q != 8'h00) : (regsIn.zeroFlag == (cnt_q[0]))) begin
						state_d = S_BRANCH;
						tLen    = T_BRANCH;
					end else begin
						state_d = S_FETCH;
						tLen    = T_FETCH;
						done_d  = 1'b1;
					end
				end
			end
			S_BRANCH: begin
				// Internal cycle: no bus activity while the target is formed
				if (lastT) begin
					pc_d    = relTarget(pc_q, disp_q);
					state_d = S_FETCH;
					tStart  = 1'b1;
					done_d  = 1'b1;
				end
			end
			S_OPLO: begin
				req.rd   = 1'b1;
				req.addr = pc_q;
				if (lastT) begin
					lo_d    = memRdata;
					pc_d    = pc_q + 16'h0001;
					state_d = S_OPHI;
					tStart  = 1'b1;
					tLen    = T_CALL_RD2;
				end
			end
			S_OPHI: begin
				req.rd   = 1'b1;
				req.addr = pc_q;
				if (lastT) begin
					tgt_d   = {memRdata, lo_q};
					pc_d    = pc_q + 16'h0001;
					sp_d    = sp_q - 16'h0001;
					state_d = S_PUSHHI;
					tStart  = 1'b1;
					tLen    = T_WRITE;
				end
			end
			S_PUSHHI: begin
				req.wr    = 1'b1;
				req.addr  = sp_q;
				req.wdata = pc_q[15:8];
				if (lastT) begin
					sp_d    = sp_q - 16'h0001;
					state_d = S_PUSHLO;
					tStart  = 1'b1;
					tLen    = T_WRITE;
				end
			end
			S_PUSHLO: begin
				req.wr    = 1'b1;
				req.addr  = sp_q;
				req.wdata = pc_q[7:0];
				if (lastT) begin
					pc_d    = tgt_q;
					state_d = S_FETCH;
					tStart  = 1'b1;
					done_d  = 1'b1;
				end
			end
			default: begin
				state_d = S_FETCH;
				tStart  = 1'b1;
			end
		endcase
		// Condition selector reuses cnt for the relative jumps: bit0 = wanted zero flag
		if (state_q == S_FETCH && lastT && (memRdata == OP_REL_Z || memRdata == OP_REL_NZ))
			cnt_d = {7'h00, memRdata == OP_REL_Z};
	end

	// Registers; out of reset the timer already holds one fetch, so fetching starts at once
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_q <= S_FETCH;
			pc_q    <= PC_RESET;
			sp_q    <= SP_RESET;
			disp_q  <= 8'h00;
			lo_q    <= 8'h00;
			tgt_q   <= 16'h0000;
			pfx_q   <= 2'h0;
			long_q  <= 1'b0;
			cnt_q   <= 8'h00;
			done_q  <= 1'b0;
			ill_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			pc_q    <= pc_d;
			sp_q    <= sp_d;
			disp_q  <= disp_d;
			lo_q    <= lo_d;
			tgt_q   <= tgt_d;
			pfx_q   <= pfx_d;
			long_q  <= long_d;
			cnt_q   <= cnt_d;
			done_q  <= done_d;
			ill_q   <= ill_d;
		end
	end

	// Outputs
	assign memReq         = req;
	assign programCounter = pc_q;
	assign stackPointer   = sp_q;
	assign instrDone      = done_q;
	assign illegalOp      = ill_q;
	assign countOut       = loopCount;
	assign countWe        = (state_q == S_FETCH2) && long_q && lastT;
	assign flagsWe        = 1'b0;

	// Checks
	AST_NO_FLAGS: assert property (@(posedge core_clk) disable iff (!nrst) !flagsWe)
		else $error("flags written");
	AST_BRANCH_FIVE: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(state_q == S_BRANCH) && $past(state_q) == S_DISP |-> (state_q == S_BRANCH)[*5] ##1 state_q == S_FETCH)
		else $error("branch cycle not five T-states");
	AST_REL_TARGET: assert property (@(posedge core_clk) disable iff (!nrst)
		state_q == S_BRANCH && lastT |=> pc_q == $past(pc_q) + {{8{$past(disp_q[7])}}, $past(disp_q)})
		else $error("bad relative target");
	AST_PUSH_ORDER: assert property (@(posedge core_clk) disable iff (!nrst)
		state_q == S_OPHI && lastT |=> memReq.wr && memReq.addr == $past(sp_q) - 16'h0001
		&& memReq.wdata == $past(pc_q[15:8] + {7'h00, &pc_q[7:0]}))
		else $error("bad push high byte");
	AST_PUSH_LO: assert property (@(posedge core_clk) disable iff (!nrst)
		state_q == S_PUSHHI && lastT |=> memReq.wr && memReq.addr == $past(sp_q) - 16'h0001)
		else $error("bad push low address");
	AST_CALL_ENTRY: assert property (@(posedge core_clk) disable iff (!nrst)
		state_q == S_PUSHLO && lastT |=> pc_q == $past(tgt_q) && instrDone)
		else $error("call entry not loaded");
	AST_PTR_JUMP: assert property (@(posedge core_clk) disable iff (!nrst)
		state_q == S_FETCH && lastT && memRdata == OP_IND_JUMP |=> pc_q == $past(regsIn.pointerPair))
		else $error("pointer pair jump wrong");
	AST_LOOP_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
		state_q == S_DISP && long_q && cnt_q == 8'h00 && lastT |=> state_q == S_FETCH)
		else $error("loop did not fall through");
endmodule

// *** verification/bce_mem_model.sv ***
`timescale 1ns/100ps
// Program and stack memory on the far side of the memory bus
module bce_mem_model
	import bce_pkg::*;
(
	// Clock
	input  wire logic      core_clk,
	// Memory bus
	input  wire bce_mreq_t memReq,
	output logic [7:0]     memRdata
);
	logic [7:0]  mem [0:65535];
	logic [7:0]  lastRd;
	logic        wrSeen;
	logic [15:0] wrAddr;
	logic [23:0] wrLog [$];

	// Cleared at start so unloaded code reads as a known opcode
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h00;
		end
		lastRd = 8'h00;
		wrSeen = 1'b0;
		wrAddr = 16'h0000;
	end

	// Answers at once; an idle bus shows the inverse of the last byte, not a stale copy
	always_comb begin
		if (memReq.rd)
			memRdata = mem[memReq.addr];
		else
			memRdata = ~lastRd;
	end

	// Stores stack bytes; each new write address is logged once for ordering checks
	always @(posedge core_clk) begin
		wrSeen <= memReq.wr;
		if (memReq.rd)
			lastRd <= mem[memReq.addr];
		if (memReq.wr) begin
			mem[memReq.addr] <= memReq.wdata;
			wrAddr <= memReq.addr;
			if (!wrSeen || wrAddr != memReq.addr)
				wrLog.push_back({memReq.addr, memReq.wdata});
		end
	end
endmodule

// *** verification/test_branch_and_call_exec.sv ***
`timescale 1ns/100ps
// Runs a short program through the branch and call unit
module test_branch_and_call_exec
	import bce_pkg::*;
;
	logic        core_clk;
	logic        nrst;
	logic [15:0] ptr;
	logic [15:0] firstIdx;
	logic [15:0] secondIdx;
	logic [7:0]  cnt;
	logic        zf;
	logic [7:0]  countOut;
	logic        countWe;
	logic        flagsWe;
	bce_mreq_t   memReq;
	logic [7:0]  memRdata;
	logic [15:0] programCounter;
	logic [15:0] stackPointer;
	logic        instrDone;
	logic        illegalOp;
	int          err_total;
	int          cmp_count;
	int          flagWrites;
	int          cntWrites;
	// Address and byte of each program location
	logic [23:0] prog [23] = '{24'h0000e9, 24'h002028, 24'h002103, 24'h002528, 24'h00267f,
		24'h002720, 24'h002805, 24'h002920, 24'h002a80, 24'hffab20, 24'hffac7f, 24'h002c10,
		24'h002dfe, 24'h002ee9, 24'h0100dd, 24'h0101e9, 24'h0200fd, 24'h0201e9, 24'h0310cd,
		24'h031135, 24'h031221, 24'h2135cd, 24'h213704};
	logic [23:0] expLog [4] = '{24'hfffe03, 24'hfffd13, 24'hfffc21, 24'hfffb38};

	branch_and_call_exec i_dut (
		.core_clk       (core_clk),
		.nrst           (nrst),
		.regsIn         (bce_regs_t'({ptr, firstIdx, secondIdx, cnt, zf})),
		.countOut       (countOut),
		.countWe        (countWe),
		.flagsWe        (flagsWe),
		.memReq         (memReq),
		.memRdata       (memRdata),
		.programCounter (programCounter),
		.stackPointer   (stackPointer),
		.instrDone      (instrDone),
		.illegalOp      (illegalOp)
	);
	bce_mem_model i_mem (
		.core_clk (core_clk),
		.memReq   (memReq),
		.memRdata (memRdata)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Register file: takes the loop count back and counts any flag write
	always @(posedge core_clk) begin
		if (countWe === 1'b1) begin
			cnt <= countOut;
			cntWrites <= cntWrites + 1;
		end
		if (flagsWe !== 1'b0)
			flagWrites <= flagWrites + 1;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Counts clocks since the last completion; back-to-back cycles make this the T-state total
	task automatic step(input logic [15:0] tgt, input int tst);
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (instrDone !== 1'b1 && n < 100);
		chk({15'h0000, instrDone}, 16'h0001);
		if (tst > 0)
			chk(16'(n), 16'(tst));
		chk(programCounter, tgt);
	endtask
	task automatic setz(input logic z);
		@(posedge core_clk);
		zf <= z;
	endtask
	task automatic sc_zero_jump;
		setz(1'b1);
		step(16'h0025, 12);
		setz(1'b0);
		step(16'h0027, 7);
	endtask
	task automatic sc_nz_range;
		setz(1'b1);
		step(16'h0029, 7);
		setz(1'b0);
		step(16'hffab, 12);
		step(16'h002c, 12);
	endtask
	task automatic sc_loop;
		@(posedge core_clk);
		ptr <= 16'h0100;
		step(16'h002c, 13);
		step(16'h002e, 8);
		chk({8'h00, cnt}, 16'h0000);
		chk(16'(cntWrites), 16'h0002);
	endtask
	task automatic sc_indirect;
		step(16'h0100, 4);
		step(16'h0200, 8);
		step(16'h0310, 8);
	endtask
	// Two calls back to back; stack bytes must land high first, then low
	task automatic sc_call;
		step(16'h2135, 17);
		chk(stackPointer, 16'hfffd);
		step(16'h0400, 17);
		chk(stackPointer, 16'hfffb);
		chk(16'(i_mem.wrLog.size()), 16'h0004);
		for (int i = 0; i < 4 && i < i_mem.wrLog.size(); i++) begin
			chk(i_mem.wrLog[i][23:8], expLog[i][23:8]);
			chk({8'h00, i_mem.wrLog[i][7:0]}, {8'h00, expLog[i][7:0]});
		end
	endtask
	task automatic sc_illegal;
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (illegalOp !== 1'b1 && n < 100);
		chk({15'h0000, illegalOp}, 16'h0001);
		chk(16'(flagWrites), 16'h0000);
	endtask
	task automatic results;
		$display("Checks %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		nrst = 1'b0;
		ptr = 16'h0020;
		firstIdx = 16'h0200;
		secondIdx = 16'h0310;
		cnt = 8'h02;
		zf = 1'b0;
		err_total = 0;
		cmp_count = 0;
		flagWrites = 0;
		cntWrites = 0;
		#1;
		foreach (prog[i])
			i_mem.mem[prog[i][23:8]] = prog[i][7:0];
		repeat (20) @(posedge core_clk);
		nrst <= 1'b1;
		step(16'h0020, 0);
		sc_zero_jump();
		sc_nz_range();
		sc_loop();
		sc_indirect();
		sc_call();
		sc_illegal();
		results();
	end

	// Whole program needs under two hundred clocks; this cuts a hang short
	initial begin
		#20000;
		err_total++;
		results();
	end
endmodule
